// ---- rtl/mgmt_port_pkg.sv ----
// Constants, types and decode helpers shared by the host port design files
package mgmt_port_pkg;

  // ****************************************
  // Command byte layout
  // ****************************************
  localparam int unsigned CMD_PREFIX_LSB = 5;        // Upper three bits pick the selector
  localparam logic [2:0] CMD_PREFIX_BANK = 3'h0;     // All zero loads the bank selector
  localparam logic [2:0] CMD_PREFIX_REG = 3'h7;      // All one loads the register selector

  // ****************************************
  // Bank numbers
  // ****************************************
  localparam logic [4:0] BANK_REPEATER = 5'h00;      // Repeater registers
  localparam logic [4:0] BANK_PORT_STATUS = 5'h01;   // Sticky event status bytes
  localparam logic [4:0] BANK_PORT_CONTROL = 5'h02;  // Interrupt enable bytes
  localparam logic [4:0] BANK_TP_FIRST = 5'h10;      // First twisted-pair port
  localparam logic [4:0] BANK_TP_LAST = 5'h17;       // Last twisted-pair port
  localparam logic [4:0] BANK_AUI = 5'h1F;           // AUI port attributes

  // ****************************************
  // Register numbers
  // ****************************************
  localparam logic [4:0] REG_SA_MATCH = 5'h0A;       // 6-byte address match value
  localparam logic [4:0] REG_TOTAL_OCTETS = 5'h0C;   // 4-byte counter
  localparam logic [4:0] REG_TX_COLLISIONS = 5'h0D;  // 4-byte counter
  localparam logic [4:0] REG_CONFIG = 5'h10;         // Configuration byte
  localparam logic [4:0] REG_VERSION = 5'h1C;        // Version byte
  localparam logic [4:0] REG_MGMT_SET = 5'h1E;       // Management port set byte
  localparam logic [4:0] REG_MGMT_GET = 5'h1F;       // Management port get byte
  localparam logic [4:0] REG_LAST_COUNTER = 5'h0C;   // Attribute counters run 0 to here
  localparam logic [4:0] REG_LAST_SA = 5'h0E;        // 6-byte last source address

  // ****************************************
  // Event sources, one status byte each
  // ****************************************
  localparam int unsigned NUM_SRC = 10;              // Status registers 0 to 9
  localparam logic [NUM_SRC-1:0] SRC_VALID = 10'h3EF;  // Register 4 is reserved
  localparam logic [NUM_SRC-1:0] SRC_TP = 10'h145;   // Sources tied to twisted-pair ports
  localparam logic [7:0] CONFIG_RESET = 8'h00;       // Configuration after reset
  localparam int unsigned CFG_MAC_MODE_BIT = 0;      // MAC interface mode enable
  localparam int unsigned CFG_IF_ERR_EN_BIT = 1;     // Interface error interrupt enable

  // ****************************************
  // Handshake timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;      // 125 MHz core clock
  localparam int unsigned HANDSHAKE_NS = 500;        // Typical cycle time
  localparam int unsigned HANDSHAKE_CYCLES =
    (HANDSHAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [4:0] bank;                                // Bank selector
    logic [4:0] regn;                                // Register selector
  } sel_t;

  // Attribute bank test
  function automatic logic is_attr_bank(input logic [4:0] bank);
    return (bank >= BANK_TP_FIRST && bank <= BANK_TP_LAST) || bank == BANK_AUI;
  endfunction

  // Byte length of the selected register
  function automatic logic [2:0] attr_len(input sel_t sel);
    if (sel.bank == BANK_REPEATER && sel.regn == REG_SA_MATCH) begin
      return 3'h6;
    end else if (sel.bank == BANK_REPEATER &&
                 (sel.regn == REG_TOTAL_OCTETS || sel.regn == REG_TX_COLLISIONS)) begin
      return 3'h4;
    end else if (is_attr_bank(sel.bank) && sel.regn == REG_LAST_SA) begin
      return 3'h6;
    end else if (is_attr_bank(sel.bank) && sel.regn <= REG_LAST_COUNTER) begin
      return 3'h4;
    end
    return 3'h1;
  endfunction

endpackage

// ---- rtl/host_strobe_sequencer.sv ----
// Strobe handshake sequencer for the asynchronous host port
`timescale 1ns/1ps
`default_nettype none

module host_strobe_sequencer #(
  parameter int unsigned HS_CYCLES = mgmt_port_pkg::HANDSHAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host strobes
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  // Cycle events
  output logic start_o,
  output logic done_o,
  output logic is_read_o,
  output logic ready_drive_o
);

  localparam int unsigned CW = $clog2(HS_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(HS_CYCLES - 1);

  typedef enum logic [1:0] {S_IDLE, S_COUNT, S_RELEASE} seq_state_t;

  seq_state_t state_q, state_d;    // Handshake phase
  logic [CW-1:0] cnt_q, cnt_d;     // Cycles left with ready held low
  logic act_q, act_d;              // Strobe activity last cycle
  logic read_q, read_d;            // Cycle is a read
  logic ready_q, ready_d;          // Ready pulled low
  logic act;                       // Select gated with either strobe
  logic own_up;                    // The strobe that opened the cycle is high

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    act = !cs_n_i && (!rd_n_i || !wr_n_i);
    own_up = cs_n_i || (read_q ? rd_n_i : wr_n_i);
    state_d = state_q;
    cnt_d = cnt_q;
    act_d = act;
    read_d = read_q;
    ready_d = ready_q;
    start_o = 1'b0;
    done_o = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        // Falling edge of a gated strobe opens a cycle
        if (act && !act_q) begin
          start_o = 1'b1;
          read_d = !rd_n_i;
          state_d = S_COUNT;
          cnt_d = CNT_LOAD;
          ready_d = 1'b1;
        end
      end
      S_COUNT: begin
        if (own_up) begin
          // Host gave up early: close the cycle anyway
          done_o = 1'b1;
          ready_d = 1'b0;
          state_d = S_IDLE;
        end else if (cnt_q == '0) begin
          ready_d = 1'b0;
          state_d = S_RELEASE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      S_RELEASE: begin
        // Rising strobe completes the transfer
        if (own_up) begin
          done_o = 1'b1;
          state_d = S_IDLE;
        end
      end
    endcase
  end

  // Register the sequencer state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      act_q <= 1'b0;
      read_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      act_q <= act_d;
      read_q <= read_d;
      ready_q <= ready_d;
    end
  end

  assign is_read_o = read_q;
  assign ready_drive_o = ready_q;

endmodule

`default_nettype wire

// ---- rtl/repeater_mgmt_host_port.sv ----
// Host processor port of the repeater management statistics device
// Summary of operation
// - Select high means command port, low data
// - Strobe falling edge pulls ready low
// - Cycle starts when select and strobe low
// - Release ready, capture write data at rise
// - Drive bus on read, release after rise
// - Handshake takes about five hundred nanoseconds
// - Reset: interrupt undriven, sources cleared, masked
// - Interrupt low while enabled source active
// - Interrupt releases after status reads clear
// - Command prefix zero loads bank selector
// - Command prefix ones loads register selector
// - First byte read copies attribute to holding
// - After last byte, sequence restarts fresh
// - Command write resets byte sequence
// - Selectors in any order, kept otherwise
// - Command port read returns status directly
// - Bank decode: repeater, status, control, ports
// - Counters 32 bits, addresses 48 bits
// - MAC mode voids twisted-pair statistics
// - Each event class separately maskable
// - Attribute values survive external reset
// - Data bus undriven unless read selected
`timescale 1ns/1ps
`default_nettype none

module repeater_mgmt_host_port #(
  parameter int unsigned HS_CYCLES = mgmt_port_pkg::HANDSHAKE_CYCLES,
  parameter logic [7:0] VERSION_ID = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // Host strobes and select
  input wire logic CS_N_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic CMD_SEL_I,
  // Host data bus, three-state
  input wire logic [7:0] HOST_DATA_I,
  output logic [7:0] HOST_DATA_O,
  output logic HOST_DATA_OE_O,
  // Open-drain ready, low while the cycle is held
  output logic READY_O,
  output logic READY_OE_O,
  // Open-drain interrupt, active low
  output logic INT_N_O,
  output logic INT_OE_O,
  // Event sources and statistics core
  input wire logic [mgmt_port_pkg::NUM_SRC-1:0][7:0] EVENT_I,
  input wire logic IF_ERR_I,
  input wire logic [47:0] ATTR_VALUE_I,
  output mgmt_port_pkg::sel_t ATTR_SEL_O,
  output logic MAC_MODE_O,
  // Management port bytes
  output logic [7:0] MGMT_SET_O,
  output logic MGMT_SET_STB_O,
  input wire logic [7:0] MGMT_GET_I
);

  localparam int unsigned NS = mgmt_port_pkg::NUM_SRC;

  // ****************************************
  // Declarations
  // ****************************************
  logic start;                          // Cycle opened this clock
  logic done;                           // Cycle closed this clock
  logic is_read;                        // Current cycle is a read
  logic ready_drive;                    // Sequencer holds ready low
  logic cmd_q, cmd_d;                   // Port latched at cycle start
  mgmt_port_pkg::sel_t sel_q, sel_d;    // Bank and register selectors
  logic [2:0] idx_q, idx_d;             // Byte position in attribute
  logic [47:0] hold_q, hold_d;          // Holding register
  logic [7:0] rdata_q, rdata_d;         // Read byte on the bus
  logic oe_q, oe_d;                     // Bus drive enable
  logic [7:0] wdata_q, wdata_d;         // Last byte seen under write strobe
  logic [NS-1:0][7:0] stat_q, stat_d;   // Sticky event status
  logic [NS-1:0][7:0] en_q, en_d;       // Interrupt enables
  logic if_err_q, if_err_d;             // Interface error pending
  logic [7:0] config_q, config_d;       // Configuration byte
  logic [47:0] sa_match_q, sa_match_d;  // Address match value
  logic [7:0] mgmt_q, mgmt_d;           // Management set byte
  logic mgmt_stb_q, mgmt_stb_d;         // Management set strobe
  logic int_q, int_d;                   // Interrupt line pulled low
  logic [2:0] len;                      // Length of selected register
  logic [47:0] cur_val;                 // Live value of selected register
  logic [7:0] status_byte;              // Command port read value
  logic [NS-1:0] ev_mask;               // Sources allowed to set
  logic [NS-1:0][7:0] clr;              // Status bytes cleared by a read
  logic mac_mode;                       // MAC interface mode
  logic last_byte;                      // Index at the final byte

  // ****************************************
  // Strobe handshake
  // ****************************************
  host_strobe_sequencer #(
    .HS_CYCLES(HS_CYCLES)
  ) u_seq (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .cs_n_i(CS_N_I),
    .rd_n_i(RD_N_I),
    .wr_n_i(WR_N_I),
    .start_o(start),
    .done_o(done),
    .is_read_o(is_read),
    .ready_drive_o(ready_drive)
  );

  // ****************************************
  // Read value selection
  // ****************************************
  always_comb begin
    mac_mode = config_q[mgmt_port_pkg::CFG_MAC_MODE_BIT];
    len = mgmt_port_pkg::attr_len(sel_q);
    last_byte = (idx_q == len - 3'h1);
    // Status summary: one bit per event class
    status_byte = {1'b0, if_err_q, |(stat_q[8] | stat_q[9]),
                   |(stat_q[6] | stat_q[7]), |stat_q[5], |stat_q[3],
                   |stat_q[2], |(stat_q[0] | stat_q[1])};
    cur_val = '0;
    // Bank decode
    if (sel_q.bank == mgmt_port_pkg::BANK_REPEATER) begin
      unique case (sel_q.regn)
        mgmt_port_pkg::REG_SA_MATCH: cur_val = sa_match_q;
        mgmt_port_pkg::REG_TOTAL_OCTETS,
        mgmt_port_pkg::REG_TX_COLLISIONS: cur_val = {16'h0000, ATTR_VALUE_I[31:0]};
        mgmt_port_pkg::REG_CONFIG: cur_val[7:0] = config_q;
        mgmt_port_pkg::REG_VERSION: cur_val[7:0] = VERSION_ID;
        mgmt_port_pkg::REG_MGMT_GET: cur_val[7:0] = MGMT_GET_I;
        default: cur_val = '0;
      endcase
    end else if (sel_q.bank == mgmt_port_pkg::BANK_PORT_STATUS) begin
      if (sel_q.regn < 5'(NS)) begin
        cur_val[7:0] = stat_q[sel_q.regn[3:0]];
      end
    end else if (sel_q.bank == mgmt_port_pkg::BANK_PORT_CONTROL) begin
      if (sel_q.regn < 5'(NS)) begin
        cur_val[7:0] = en_q[sel_q.regn[3:0]];
      end
    end else if (mgmt_port_pkg::is_attr_bank(sel_q.bank)) begin
      // Twisted-pair figures are void in MAC mode
      if (!(mac_mode && sel_q.bank != mgmt_port_pkg::BANK_AUI)) begin
        if (sel_q.regn == mgmt_port_pkg::REG_LAST_SA) begin
          cur_val = ATTR_VALUE_I;
        end else if (sel_q.regn <= mgmt_port_pkg::REG_LAST_COUNTER) begin
          cur_val = {16'h0000, ATTR_VALUE_I[31:0]};
        end
      end
    end
  end

  // ****************************************
  // Host access next state
  // ****************************************
  always_comb begin
    cmd_d = cmd_q;
    sel_d = sel_q;  // Unwritten selector keeps its value
    idx_d = idx_q;
    hold_d = hold_q;
    rdata_d = rdata_q;
    oe_d = oe_q;
    config_d = config_q;
    sa_match_d = sa_match_q;
    mgmt_d = mgmt_q;
    mgmt_stb_d = 1'b0;
    en_d = en_q;
    clr = '0;
    if_err_d = if_err_q;
    // Track the bus while the write strobe is low
    wdata_d = (!CS_N_I && !WR_N_I) ? HOST_DATA_I : wdata_q;
    if (start) begin
      cmd_d = CMD_SEL_I;
      if (!RD_N_I) begin
        oe_d = 1'b1;
        if (CMD_SEL_I) begin
          rdata_d = status_byte;
        end else if (idx_q == 3'h0) begin
          rdata_d = cur_val[7:0];
          if (len > 3'h1) begin
            hold_d = cur_val;
          end
        end else begin
          rdata_d = hold_q[8*idx_q +: 8];
        end
      end
    end
    if (done) begin
      oe_d = 1'b0;
      if (is_read && cmd_q) begin
        if_err_d = 1'b0;
      end else if (is_read) begin
        if (len > 3'h1) begin
          idx_d = last_byte ? 3'h0 : idx_q + 3'h1;
        end
        if (sel_q.bank == mgmt_port_pkg::BANK_PORT_STATUS && sel_q.regn < 5'(NS)) begin
          clr[sel_q.regn[3:0]] = 8'hFF;
        end
      end else if (cmd_q) begin
        idx_d = 3'h0;
        if (wdata_q[7:mgmt_port_pkg::CMD_PREFIX_LSB] == mgmt_port_pkg::CMD_PREFIX_BANK) begin
          sel_d.bank = wdata_q[4:0];
        end else if (wdata_q[7:mgmt_port_pkg::CMD_PREFIX_LSB] ==
                     mgmt_port_pkg::CMD_PREFIX_REG) begin
          sel_d.regn = wdata_q[4:0];
        end
      end else if (sel_q.bank == mgmt_port_pkg::BANK_REPEATER) begin
        if (sel_q.regn == mgmt_port_pkg::REG_SA_MATCH) begin
          // Address match is written low byte first
          hold_d[8*idx_q +: 8] = wdata_q;
          idx_d = last_byte ? 3'h0 : idx_q + 3'h1;
          if (last_byte) begin
            sa_match_d = hold_d;
          end
        end else if (sel_q.regn == mgmt_port_pkg::REG_CONFIG) begin
          config_d = wdata_q;
        end else if (sel_q.regn == mgmt_port_pkg::REG_MGMT_SET ||
                     sel_q.regn == mgmt_port_pkg::REG_MGMT_GET) begin
          mgmt_d = wdata_q;
          mgmt_stb_d = 1'b1;
        end
      end else if (sel_q.bank == mgmt_port_pkg::BANK_PORT_CONTROL && sel_q.regn < 5'(NS)) begin
        en_d[sel_q.regn[3:0]] = wdata_q;
      end
    end
    // Interface error sets over its own clear
    if (IF_ERR_I) begin
      if_err_d = 1'b1;
    end
  end

  // ****************************************
  // Event status and interrupt
  // ****************************************
  always_comb begin
    ev_mask = mgmt_port_pkg::SRC_VALID & ~(mac_mode ? mgmt_port_pkg::SRC_TP : '0);
    int_d = if_err_q && config_q[mgmt_port_pkg::CFG_IF_ERR_EN_BIT];
    for (int i = 0; i < NS; i++) begin
      // New events win over the clearing read
      stat_d[i] = (stat_q[i] & ~clr[i]) | (EVENT_I[i] & {8{ev_mask[i]}});
      int_d = int_d || |(stat_q[i] & en_q[i]);
    end
  end

  // ****************************************
  // Control registers with reset
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmd_q <= 1'b0;
      sel_q <= '0;
      idx_q <= 3'h0;
      rdata_q <= 8'h00;
      oe_q <= 1'b0;
      wdata_q <= 8'h00;
      stat_q <= '0;
      en_q <= '0;
      if_err_q <= 1'b0;
      config_q <= mgmt_port_pkg::CONFIG_RESET;
      mgmt_q <= 8'h00;
      mgmt_stb_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
      oe_q <= oe_d;
      wdata_q <= wdata_d;
      stat_q <= stat_d;
      en_q <= en_d;
      if_err_q <= if_err_d;
      config_q <= config_d;
      mgmt_q <= mgmt_d;
      mgmt_stb_q <= mgmt_stb_d;
      int_q <= int_d;
    end
  end

  // ****************************************
  // Attribute storage kept through reset
  // ****************************************
  always_ff @(posedge CORE_CLK_I) begin
    hold_q <= hold_d;
    sa_match_q <= sa_match_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign HOST_DATA_O = rdata_q;
  assign HOST_DATA_OE_O = oe_q;
  assign READY_O = 1'b0;
  assign READY_OE_O = ready_drive;
  assign INT_N_O = 1'b0;
  assign INT_OE_O = int_q;
  assign ATTR_SEL_O = sel_q;
  assign MAC_MODE_O = mac_mode;
  assign MGMT_SET_O = mgmt_q;
  assign MGMT_SET_STB_O = mgmt_stb_q;

endmodule

`default_nettype wire

// ---- verif/host_port_asserts.sv ----
// Concurrent checks on the host port of the management device
`timescale 1ns/1ps
`default_nettype none

module host_port_asserts #(
  parameter int unsigned HS_CYCLES = 4
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // Host strobes and select
  input wire logic CS_N_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic CMD_SEL_I,
  // Device outputs
  input wire logic HOST_DATA_OE_O,
  input wire logic READY_OE_O,
  input wire logic INT_OE_O,
  input wire mgmt_port_pkg::sel_t ATTR_SEL_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  logic act;         // Select and one strobe both low
  logic [7:0] hold_q;  // Cycles that ready has been held low
  logic [7:0] hold_d;
  assign act = !CS_N_I && (!RD_N_I || !WR_N_I);

  // Next value of the ready hold counter
  always_comb begin
    hold_d = READY_OE_O ? hold_q + 8'h01 : 8'h00;
  end

  // Registers the ready hold counter
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hold_q <= 8'h00;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ****************************************
  // Handshake sequences
  // ****************************************
  sequence s_start;
    $rose(act) && !READY_OE_O;
  endsequence
  sequence s_read_open;
    $rose(READY_OE_O) && !RD_N_I && !CS_N_I;
  endsequence

  a_ready_pull: assert property (s_start |=> READY_OE_O)
    else $error("ready not pulled after strobe");
  a_ready_time: assert property ($fell(READY_OE_O) |-> hold_q == 8'(HS_CYCLES))
    else $error("ready held for wrong count");
  a_ready_cap: assert property (hold_q <= 8'(HS_CYCLES))
    else $error("ready held too long");
  a_read_drive: assert property (s_read_open |-> HOST_DATA_OE_O)
    else $error("bus not driven on read");
  a_bus_owner: assert property (HOST_DATA_OE_O |-> !$past(RD_N_I) && !$past(CS_N_I))
    else $error("bus driven without read");
  a_write_quiet: assert property (!WR_N_I |-> !HOST_DATA_OE_O)
    else $error("bus driven during write");
  a_int_reset: assert property ($rose(RESETN_I) |-> !INT_OE_O)
    else $error("interrupt driven after reset");
  a_int_release: assert property ($fell(INT_OE_O) |->
      $past(HOST_DATA_OE_O) || $past(HOST_DATA_OE_O, 2) || $past(HOST_DATA_OE_O, 3))
    else $error("interrupt released without read");
  a_sel_cause: assert property ($changed(ATTR_SEL_O) |->
      $past(CMD_SEL_I) && !$past(WR_N_I, 2))
    else $error("selector changed without command write");
endmodule

bind repeater_mgmt_host_port host_port_asserts #(.HS_CYCLES(HS_CYCLES)) chk_u (
  .CORE_CLK_I(CORE_CLK_I),
  .RESETN_I(RESETN_I),
  .CS_N_I(CS_N_I),
  .RD_N_I(RD_N_I),
  .WR_N_I(WR_N_I),
  .CMD_SEL_I(CMD_SEL_I),
  .HOST_DATA_OE_O(HOST_DATA_OE_O),
  .READY_OE_O(READY_OE_O),
  .INT_OE_O(INT_OE_O),
  .ATTR_SEL_O(ATTR_SEL_O)
);

`default_nettype wire

// ---- verif/host_cpu_model.sv ----
// Behavioural host processor on the asynchronous byte bus
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model (
  // Clock and wire levels
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [7:0] bus_i,
  // Host strobes and data
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cmd_o,
  output logic [7:0] data_o
);
  // Idle bus state at time zero
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cmd_o = 1'b0;
    data_o = 8'h00;
  end

  // One strobe cycle; ok is low when ready never completes
  task automatic xfer(input logic rd, input logic cmd, input logic [7:0] wd,
                      output logic [7:0] q, output logic ok);
    int n;
    logic seen;
    seen = 1'b0;
    ok = 1'b0;
    q = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    cmd_o = cmd;
    data_o = rd ? ~data_o : wd;  // Write byte placed with the strobe
    rd_n_o = !rd;
    wr_n_o = rd;
    for (n = 0; n < 100 && !ok; n++) begin
      @(negedge clk_i);
      if (!ready_i) begin
        seen = 1'b1;
      end else if (seen) begin
        ok = 1'b1;
        q = bus_i;  // Byte taken as ready releases
      end
    end
    rd_n_o = 1'b1;  // Strobe held until ready released
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    @(negedge clk_i);
    data_o = ~data_o;  // Bus let go only after the rising strobe
  endtask

  // Read strobe with chip select high; hit shows any ready pull
  task automatic stray(output logic hit);
    hit = 1'b0;
    @(negedge clk_i);
    rd_n_o = 1'b0;
    repeat (3) begin
      @(negedge clk_i);
      hit = hit | !ready_i;
    end
    @(negedge clk_i);
    rd_n_o = 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [7:0] VID = 8'h3C;  // Arbitrary version value
  localparam logic [47:0] VA = 48'h1122_3344_5566;
  localparam logic [47:0] VB = 48'h0000_DDCC_BBAA;
  logic clk, rst_n, cs_n, rd_n, wr_n, cmd, hd_oe, rdy_oe, int_oe, mac, stb, ife;
  logic [7:0] hd_o, host_d, set_b, get_b;
  logic [9:0][7:0] ev;
  logic [47:0] av;
  mgmt_port_pkg::sel_t sel;
  wire logic [7:0] hd_w = hd_oe ? hd_o : host_d;  // Resolved data bus
  int bad_count;
  int comparisons;

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  repeater_mgmt_host_port #(.HS_CYCLES(4), .VERSION_ID(VID)) dut_u (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .CMD_SEL_I(cmd), .HOST_DATA_I(hd_w), .HOST_DATA_O(hd_o),
    .HOST_DATA_OE_O(hd_oe), .READY_O(), .READY_OE_O(rdy_oe), .INT_N_O(),
    .INT_OE_O(int_oe), .EVENT_I(ev), .IF_ERR_I(ife), .ATTR_VALUE_I(av),
    .ATTR_SEL_O(sel), .MAC_MODE_O(mac), .MGMT_SET_O(set_b),
    .MGMT_SET_STB_O(stb), .MGMT_GET_I(get_b));

  host_cpu_model host_u (.clk_i(clk), .ready_i(!rdy_oe), .bus_i(hd_w), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .cmd_o(cmd), .data_o(host_d));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic r, input logic c, input logic [7:0] w, output logic [7:0] q);
    logic ok;
    host_u.xfer(r, c, w, q, ok);
    if (!ok) begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic pick(input logic [4:0] b, input logic [4:0] r);
    logic [7:0] q;
    xfer(1'b0, 1'b1, {3'h0, b}, q);
    xfer(1'b0, 1'b1, {3'h7, r}, q);
  endtask

  // Checks a run of data-port reads against a value, from byte lo to hi
  task automatic rd_bytes(input logic [47:0] v, input int lo, input int hi);
    logic [7:0] q;
    for (int i = lo; i <= hi; i++) begin
      xfer(1'b1, 1'b0, 8'h00, q);
      chk("data byte", 16'(v[8*i+:8]), 16'(q));
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] q;
    chk("int after reset", 16'h0000, 16'(int_oe));
    chk("sel after reset", 16'h0000, 16'(sel));
    xfer(1'b1, 1'b1, 8'h00, q);
    chk("status", 16'h0000, 16'(q));
    ife = 1'b1;
    @(negedge clk);
    ife = 1'b0;
    xfer(1'b1, 1'b1, 8'h00, q);
    chk("if error", 16'h0040, 16'(q));
    host_u.stray(q[0]);
    chk("ungated ready", 16'h0000, 16'(q[0]));
    $display("test reset done");
  endtask

  task automatic t_select();
    logic [7:0] q;
    xfer(1'b0, 1'b1, 8'hFF, q);
    xfer(1'b0, 1'b1, 8'h05, q);
    chk("sel order", 16'h00BF, 16'(sel));
    xfer(1'b0, 1'b1, 8'h42, q);
    chk("sel bad prefix", 16'h00BF, 16'(sel));
    xfer(1'b0, 1'b1, 8'h1F, q);
    chk("sel kept reg", 16'h03FF, 16'(sel));
    $display("test select done");
  endtask

  task automatic t_events();
    int s[9] = '{0, 1, 2, 3, 5, 6, 7, 8, 9};
    int b[9] = '{0, 0, 1, 2, 3, 4, 4, 5, 5};
    logic [7:0] q;
    for (int i = 0; i < 9; i++) begin
      ev[s[i]] = 8'h81;
      @(negedge clk);
      ev[s[i]] = 8'h00;
      xfer(1'b1, 1'b1, 8'h00, q);
      chk("status bit", 16'(8'h01 << b[i]), 16'(q));
      chk("masked int", 16'h0000, 16'(int_oe));
      pick(5'h02, 5'(s[i]));
      xfer(1'b0, 1'b0, 8'h80, q);
      repeat (3) @(negedge clk);
      chk("enabled int", 16'h0001, 16'(int_oe));
      pick(5'h01, 5'(s[i]));
      xfer(1'b1, 1'b0, 8'h00, q);
      chk("status byte", 16'h0081, 16'(q));
      repeat (3) @(negedge clk);
      chk("cleared int", 16'h0000, 16'(int_oe));
    end
    $display("test events done");
  endtask

  task automatic t_attr();
    logic [7:0] q;
    pick(5'h10, 5'h00);
    av = VA;
    rd_bytes(VA, 0, 1);
    av = VB;
    rd_bytes(VA, 2, 3);
    rd_bytes(VB, 0, 1);
    xfer(1'b0, 1'b1, 8'hE0, q);
    rd_bytes(VB, 0, 0);
    pick(5'h1F, 5'h0E);
    av = VA;
    rd_bytes(VA, 0, 5);
    rd_bytes(VA, 0, 0);
    $display("test attributes done");
  endtask

  task automatic t_single();
    logic [7:0] q;
    pick(5'h00, 5'h1C);
    rd_bytes({40'h0, VID}, 0, 0);
    rd_bytes({40'h0, VID}, 0, 0);
    pick(5'h00, 5'h1F);
    rd_bytes({40'h0, get_b}, 0, 0);
    pick(5'h00, 5'h1E);
    xfer(1'b0, 1'b0, 8'h96, q);
    chk("set byte", 16'h0096, 16'(set_b));
    chk("set strobe", 16'h0001, 16'(stb));
    pick(5'h00, 5'h0A);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 1'b0, VB[8*i+:8], q);
    end
    rd_bytes(VB, 0, 5);
    $display("test single done");
  endtask

  task automatic t_mac();
    logic [7:0] q;
    pick(5'h00, 5'h10);
    xfer(1'b0, 1'b0, 8'h01, q);
    chk("mac mode", 16'h0001, 16'(mac));
    rd_bytes(48'h01, 0, 0);
    pick(5'h10, 5'h00);
    rd_bytes(48'h0, 0, 3);
    pick(5'h00, 5'h10);
    xfer(1'b0, 1'b0, 8'h00, q);
    chk("mac off", 16'h0000, 16'(mac));
    $display("test mac done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ev = '0;
    av = '0;
    ife = 1'b0;
    get_b = 8'hC3;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_select();
    t_events();
    t_attr();
    t_single();
    t_mac();
    close_out();
  end
endmodule

`default_nettype wire
